// ### hdl/fpq_top.sv
`timescale 1ns/100ps
`include "fpq_cfg.svh"
module fpq_top
	import fpq_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [`FPQ_ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic cycleStartPin,
	input wire logic overcurrentPin,
	input wire logic openLoopPin,
	input wire logic outputOvervoltagePin,
	input wire logic boostOvervoltagePin,
	input wire logic clampOverpowerPin,
	input wire logic lineLinkPin,
	input wire logic externalOvertempPin,
	input wire logic internalOvertempPin,
	output logic secondStageOff,
	output logic outputOvervoltageFault,
	output logic boostOvervoltageFault,
	output logic clampOverpowerFault,
	output logic lineLinkFault,
	output logic externalOvertempFault,
	output logic internalOvertempFault,
	output logic tempSampleStrobe,
	output logic irq
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [8:0] pinMeta;
	logic [8:0] pinSync;
	wire [8:0] pinRaw = {internalOvertempPin, externalOvertempPin, lineLinkPin, clampOverpowerPin,
		boostOvervoltagePin, outputOvervoltagePin, openLoopPin, overcurrentPin, cycleStartPin};
	logic cycPrev;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinMeta <= 9'h000;
			pinSync <= 9'h000;
			cycPrev <= 1'b0;
		end
		else
		begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
			cycPrev <= pinSync[0];
		end
	end

	fpq_stage_s stage;
	assign stage.cycleStart = pinSync[0] && !cycPrev;
	assign stage.overcurrent = pinSync[1];
	assign stage.openLoop = pinSync[2];

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	fpq_cfg_s cfg;
	logic [7:0] irqStatus;
	logic [7:0] irqEnable;

	wire [7:0] regIdx = wb_adr_i[`FPQ_ADDR_W-1:2];
	wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wrLane0 = busReq && wb_we_i && wb_sel_i[0];
	wire hitProt = (regIdx == `FPQ_IDX_PROT_EN);
	wire hitBlank = (regIdx == `FPQ_IDX_BLANK);
	wire hitCount = (regIdx == `FPQ_IDX_COUNT);
	wire hitRestart = (regIdx == `FPQ_IDX_RESTART);
	wire hitStatus = (regIdx == `FPQ_IDX_STATUS);
	wire hitIrqEn = (regIdx == `FPQ_IDX_IRQ_EN);
	wire hitIrqClr = (regIdx == `FPQ_IDX_IRQ_CLR);
	wire hitFault = (regIdx == `FPQ_IDX_FAULT);
	wire [7:0] faultVector;
	wire [7:0] faultEvents;
	wire [7:0] clrMask = (wrLane0 && hitIrqClr) ? wb_dat_i[7:0] : 8'h00;
	wire [7:0] readByte = hitProt ? cfg.protEn :
		hitBlank ? cfg.blank :
		hitCount ? cfg.count :
		hitRestart ? cfg.restart :
		hitStatus ? irqStatus :
		hitIrqEn ? irqEnable :
		hitFault ? faultVector : 8'h00;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg <= {`FPQ_RST_REG, `FPQ_RST_REG, `FPQ_RST_REG, `FPQ_RST_REG};
			irqEnable <= `FPQ_RST_REG;
			irqStatus <= `FPQ_RST_REG;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? {24'h000000, readByte} : 32'h00000000;
			if (wrLane0 && hitProt)
				cfg.protEn <= wb_dat_i[7:0];
			if (wrLane0 && hitBlank)
				cfg.blank <= wb_dat_i[7:0];
			if (wrLane0 && hitCount)
				cfg.count <= wb_dat_i[7:0];
			if (wrLane0 && hitRestart)
				cfg.restart <= wb_dat_i[7:0];
			if (wrLane0 && hitIrqEn)
				irqEnable <= wb_dat_i[7:0];
			// New events win over a clear in the same cycle
			irqStatus <= (irqStatus & ~clrMask) | faultEvents;
		end
	end

	// ----------------------------------------------------------------
	// Blanking, restart tick and enables
	// ----------------------------------------------------------------
	wire ocOn = !cfg.protEn[`FPQ_EN_OC];
	wire olOn = !cfg.protEn[`FPQ_EN_OL];
	wire [15:0] ocBlank = 16'(`FPQ_OC_BASE_CYC) +
		16'(`FPQ_OC_STEP_CYC) * {12'h000, cfg.blank[`FPQ_OC_BLANK_HI:`FPQ_OC_BLANK_LO]};
	wire [15:0] olBlank = 16'(`FPQ_OL_BASE_CYC) +
		16'(`FPQ_OL_STEP_CYC) * {13'h0, cfg.blank[`FPQ_OL_BLANK_HI:`FPQ_OL_BLANK_LO]};

	logic [22:0] tickCnt;
	logic restartTick;
	wire [22:0] tickLimit = cfg.restart[`FPQ_RST_SLOW] ? 23'(`FPQ_TICK_SLOW_CYC - 1) :
		23'(`FPQ_TICK_FAST_CYC - 1);
	wire tickWrap = (tickCnt >= tickLimit);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tickCnt <= 23'h000000;
			restartTick <= 1'b0;
		end
		else
		begin
			tickCnt <= tickWrap ? 23'h000000 : tickCnt + 23'h000001;
			restartTick <= tickWrap;
		end
	end

	// ----------------------------------------------------------------
	// Cycle-qualified detectors
	// ----------------------------------------------------------------
	logic ocFault;
	logic olFault;
	logic ocEvent;
	logic olEvent;

	fpq_qualifier u_oc (
		.clock(clock),
		.rst_n(rst_n),
		.enable(ocOn),
		.cycleStart(stage.cycleStart),
		.detect(stage.overcurrent),
		.blankCycles(ocBlank),
		.threshold(cfg.count[`FPQ_OC_CNT_HI:`FPQ_OC_CNT_LO]),
		.latchSel(cfg.count[`FPQ_OC_LATCH]),
		.restartTick(restartTick),
		.restartCount(cfg.restart[`FPQ_RST_CNT_HI:`FPQ_RST_CNT_LO]),
		.fault(ocFault),
		.faultEvent(ocEvent)
	);

	fpq_qualifier u_ol (
		.clock(clock),
		.rst_n(rst_n),
		.enable(olOn),
		.cycleStart(stage.cycleStart),
		.detect(stage.openLoop),
		.blankCycles(olBlank),
		.threshold(cfg.count[`FPQ_OL_CNT_HI:`FPQ_OL_CNT_LO]),
		.latchSel(cfg.count[`FPQ_OL_LATCH]),
		.restartTick(restartTick),
		.restartCount(cfg.restart[`FPQ_RST_CNT_HI:`FPQ_RST_CNT_LO]),
		.fault(olFault),
		.faultEvent(olEvent)
	);

	// ----------------------------------------------------------------
	// Level detectors gated by enables
	// ----------------------------------------------------------------
	wire ovNow = pinSync[3] && !cfg.protEn[`FPQ_EN_OV];
	wire boNow = pinSync[4] && !cfg.protEn[`FPQ_EN_BO];
	wire coNow = pinSync[5] && !cfg.protEn[`FPQ_EN_CO];
	wire llNow = pinSync[6] && !cfg.protEn[`FPQ_EN_LL];
	wire etNow = pinSync[7] && !cfg.protEn[`FPQ_EN_ET];
	wire itNow = pinSync[8] && !cfg.protEn[`FPQ_EN_IT];

	assign faultVector = {itNow, etNow, llNow, coNow, boNow, ovNow, olFault, ocFault};
	assign faultEvents = {itNow && !internalOvertempFault, etNow && !externalOvertempFault,
		llNow && !lineLinkFault, coNow && !clampOverpowerFault, boNow && !boostOvervoltageFault,
		ovNow && !outputOvervoltageFault, olEvent, ocEvent};

	// ----------------------------------------------------------------
	// Temperature sample pacing
	// ----------------------------------------------------------------
	logic [15:0] sampCnt;
	wire [15:0] sampLimit = (cfg.blank[`FPQ_TEMP_SLOW] && !internalOvertempFault) ?
		16'(`FPQ_TSAMP_SLOW_CYC - 1) : 16'(`FPQ_TSAMP_FAST_CYC - 1);
	wire sampWrap = (sampCnt >= sampLimit);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sampCnt <= 16'h0000;
			tempSampleStrobe <= 1'b0;
			secondStageOff <= 1'b0;
			outputOvervoltageFault <= 1'b0;
			boostOvervoltageFault <= 1'b0;
			clampOverpowerFault <= 1'b0;
			lineLinkFault <= 1'b0;
			externalOvertempFault <= 1'b0;
			internalOvertempFault <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			sampCnt <= sampWrap ? 16'h0000 : sampCnt + 16'h0001;
			tempSampleStrobe <= sampWrap;
			secondStageOff <= ocFault || olFault;
			outputOvervoltageFault <= ovNow;
			boostOvervoltageFault <= boNow;
			clampOverpowerFault <= coNow;
			lineLinkFault <= llNow;
			externalOvertempFault <= etNow;
			internalOvertempFault <= itNow;
			irq <= |(irqStatus & irqEnable);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_oc_disable: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(ocOn) |-> !ocEvent) else $error("overcurrent fired while disabled");
	chk_ol_disable: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(olOn) |-> !olEvent) else $error("open loop fired while disabled");
	chk_ov_gate: assert property (@(posedge clock) disable iff (!rst_n)
		cfg.protEn[`FPQ_EN_OV] |=> !outputOvervoltageFault) else $error("overvoltage not gated");
	chk_bo_gate: assert property (@(posedge clock) disable iff (!rst_n)
		pinSync[4] && !cfg.protEn[`FPQ_EN_BO] |=> boostOvervoltageFault) else $error("boost not reported");
	chk_ll_gate: assert property (@(posedge clock) disable iff (!rst_n)
		cfg.protEn[`FPQ_EN_LL] |=> !lineLinkFault) else $error("line link not gated");
	chk_et_gate: assert property (@(posedge clock) disable iff (!rst_n)
		pinSync[7] && !cfg.protEn[`FPQ_EN_ET] |=> externalOvertempFault) else $error("ext temp missed");
	chk_it_gate: assert property (@(posedge clock) disable iff (!rst_n)
		cfg.protEn[`FPQ_EN_IT] |=> !internalOvertempFault) else $error("int temp not gated");
	chk_oc_blank: assert property (@(posedge clock) disable iff (!rst_n)
		stage.cycleStart |=> u_oc.blankCnt == ocBlank) else $error("overcurrent blank load wrong");
	chk_ol_blank: assert property (@(posedge clock) disable iff (!rst_n)
		stage.cycleStart |=> u_ol.blankCnt == olBlank) else $error("open loop blank load wrong");
	chk_temp_fast: assert property (@(posedge clock) disable iff (!rst_n)
		tempSampleStrobe |=> !tempSampleStrobe) else $error("sample strobe too long");
	chk_oc_force: assert property (@(posedge clock) disable iff (!rst_n)
		ocOn && cfg.count[`FPQ_OC_CNT_HI:`FPQ_OC_CNT_LO] == 3'h0 ##1
		ocOn && cfg.count[`FPQ_OC_CNT_HI:`FPQ_OC_CNT_LO] == 3'h0 |=> ##[0:1] ocFault)
		else $error("forced fault absent");
	chk_oc_latch: assert property (@(posedge clock) disable iff (!rst_n)
		u_oc.state == FPQ_FAULT_LATCHED |=> ocFault ##1 ocFault) else $error("latched fault dropped");
	chk_stage_off: assert property (@(posedge clock) disable iff (!rst_n)
		ocFault |=> secondStageOff) else $error("stage not disabled");
	chk_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
		|(irqStatus & irqEnable) |=> irq) else $error("interrupt missing");
endmodule

// ### hdl/fpq_cfg.svh
`ifndef FPQ_CFG_SVH
`define FPQ_CFG_SVH
// ----------------------------------------------------------------
// Register map (indices; byte address is four times the index)
// ----------------------------------------------------------------
`define FPQ_IDX_PROT_EN 8'h4f
`define FPQ_IDX_BLANK 8'h50
`define FPQ_IDX_COUNT 8'h51
`define FPQ_IDX_RESTART 8'h60
`define FPQ_IDX_STATUS 8'h61
`define FPQ_IDX_IRQ_EN 8'h62
`define FPQ_IDX_IRQ_CLR 8'h63
`define FPQ_IDX_FAULT 8'h64
`define FPQ_ADDR_W 10
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPQ_EN_OC 7
`define FPQ_EN_OL 6
`define FPQ_EN_OV 5
`define FPQ_EN_BO 4
`define FPQ_EN_CO 3
`define FPQ_EN_LL 2
`define FPQ_EN_ET 1
`define FPQ_EN_IT 0
`define FPQ_OC_BLANK_HI 7
`define FPQ_OC_BLANK_LO 4
`define FPQ_OL_BLANK_HI 3
`define FPQ_OL_BLANK_LO 1
`define FPQ_TEMP_SLOW 0
`define FPQ_OC_CNT_HI 7
`define FPQ_OC_CNT_LO 5
`define FPQ_OC_LATCH 4
`define FPQ_OL_CNT_HI 3
`define FPQ_OL_CNT_LO 1
`define FPQ_OL_LATCH 0
`define FPQ_RST_CNT_HI 7
`define FPQ_RST_CNT_LO 2
`define FPQ_RST_SLOW 1
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FPQ_RST_REG 8'h00
// ----------------------------------------------------------------
// Timing at 200 MHz (5 ns period)
// ----------------------------------------------------------------
`define FPQ_CLK_PS 5000
`define FPQ_OC_BASE_PS 150000
`define FPQ_OC_STEP_PS 50000
`define FPQ_OL_BASE_PS 1000000
`define FPQ_OL_STEP_PS 500000
`define FPQ_OC_BASE_CYC (`FPQ_OC_BASE_PS / `FPQ_CLK_PS)
`define FPQ_OC_STEP_CYC (`FPQ_OC_STEP_PS / `FPQ_CLK_PS)
`define FPQ_OL_BASE_CYC (`FPQ_OL_BASE_PS / `FPQ_CLK_PS)
`define FPQ_OL_STEP_CYC (`FPQ_OL_STEP_PS / `FPQ_CLK_PS)
`define FPQ_TICK_FAST_NS 25600
`define FPQ_TICK_SLOW_NS 40960000
`define FPQ_CLK_NS 5
`define FPQ_TICK_FAST_CYC (`FPQ_TICK_FAST_NS / `FPQ_CLK_NS)
`define FPQ_TICK_SLOW_CYC (`FPQ_TICK_SLOW_NS / `FPQ_CLK_NS)
`define FPQ_TSAMP_FAST_CYC 2560
`define FPQ_TSAMP_SLOW_CYC 40960
`endif

// ### hdl/fpq_pkg.sv
package fpq_pkg;
	typedef struct packed {
		logic [7:0] protEn;
		logic [7:0] blank;
		logic [7:0] count;
		logic [7:0] restart;
	} fpq_cfg_s;

	typedef struct packed {
		logic cycleStart;
		logic overcurrent;
		logic openLoop;
	} fpq_stage_s;

	typedef enum logic [1:0] {FPQ_OK, FPQ_FAULT_UNLATCHED, FPQ_RESTART_WAIT, FPQ_FAULT_LATCHED} fpq_state_e;
endpackage

// ### hdl/fpq_qualifier.sv
`timescale 1ns/100ps
`include "fpq_cfg.svh"
// Qualifies one cycle-gated detector: blanking, consecutive count, latch/unlatch, restart.
module fpq_qualifier
	import fpq_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic cycleStart,
	input wire logic detect,
	input wire logic [15:0] blankCycles,
	input wire logic [2:0] threshold,
	input wire logic latchSel,
	input wire logic restartTick,
	input wire logic [5:0] restartCount,
	output logic fault,
	output logic faultEvent
);
	fpq_state_e state;
	fpq_state_e next_state;
	logic [15:0] blankCnt;
	logic [2:0] eventCnt;
	logic seenInCycle;
	logic [5:0] restartCnt;

	wire blanking = (blankCnt != 16'h0000);
	wire qualified = enable && detect && !blanking;
	wire reachThresh = (threshold == 3'h0) || ((eventCnt + 3'h1) >= threshold);
	wire closeCycle = cycleStart && (state == FPQ_OK);
	wire trip = enable && (threshold == 3'h0 || (closeCycle && seenInCycle && reachThresh));

	always_comb
	begin
		next_state = state;
		case (state)
			FPQ_OK:
				if (trip)
					next_state = latchSel ? FPQ_FAULT_LATCHED : FPQ_FAULT_UNLATCHED;
			FPQ_FAULT_UNLATCHED:
				next_state = FPQ_RESTART_WAIT;
			FPQ_RESTART_WAIT:
				if (restartTick && restartCnt >= restartCount)
					next_state = FPQ_OK;
			FPQ_FAULT_LATCHED:
				next_state = FPQ_FAULT_LATCHED;
			default:
				next_state = FPQ_OK;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= FPQ_OK;
			blankCnt <= 16'h0000;
			eventCnt <= 3'h0;
			seenInCycle <= 1'b0;
			restartCnt <= 6'h00;
			fault <= 1'b0;
			faultEvent <= 1'b0;
		end
		else
		begin
			state <= next_state;
			fault <= (next_state != FPQ_OK);
			faultEvent <= (state == FPQ_OK) && (next_state != FPQ_OK);
			blankCnt <= cycleStart ? blankCycles : (blanking ? blankCnt - 16'h0001 : blankCnt);
			if (cycleStart)
			begin
				seenInCycle <= 1'b0;
				// A cycle with no qualified event clears the run
				eventCnt <= seenInCycle ? (trip ? 3'h0 : eventCnt + 3'h1) : 3'h0;
			end
			else if (qualified)
				seenInCycle <= 1'b1;
			if (state != FPQ_RESTART_WAIT)
				restartCnt <= 6'h00;
			else if (restartTick)
				restartCnt <= restartCnt + 6'h01;
		end
	end
endmodule

// ### verification/test_fpq_top.sv
`timescale 1ns/100ps
`include "fpq_cfg.svh"
module test_fpq_top
	import fpq_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [`FPQ_ADDR_W-1:0] wbAdr = '0;
	logic [31:0] wbDatI = '0;
	logic [31:0] wbDatO;
	logic [3:0] wbSel = '0;
	logic wbWe = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbAck;
	logic cycStart = 1'b0;
	logic ocPin = 1'b0;
	logic olPin = 1'b0;
	logic [5:0] lvlPin = '0;
	logic [5:0] lvlFault;
	logic secondStageOff;
	logic tempStrobe;
	logic irq;
	int failures = 0;
	int compares = 0;

	always #2.5 clock = ~clock;

	fpq_top i_fpq_top (.clock(clock), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
		.cycleStartPin(cycStart), .overcurrentPin(ocPin), .openLoopPin(olPin),
		.outputOvervoltagePin(lvlPin[5]), .boostOvervoltagePin(lvlPin[4]), .clampOverpowerPin(lvlPin[3]),
		.lineLinkPin(lvlPin[2]), .externalOvertempPin(lvlPin[1]), .internalOvertempPin(lvlPin[0]),
		.secondStageOff(secondStageOff), .outputOvervoltageFault(lvlFault[5]),
		.boostOvervoltageFault(lvlFault[4]), .clampOverpowerFault(lvlFault[3]), .lineLinkFault(lvlFault[2]),
		.externalOvertempFault(lvlFault[1]), .internalOvertempFault(lvlFault[0]),
		.tempSampleStrobe(tempStrobe), .irq(irq));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] sel,
		output logic [31:0] rd);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbAdr <= {idx, 2'b00};
		wbWe <= we;
		wbDatI <= {24'h000000, wd};
		wbSel <= sel;
		@(posedge clock);
		while (wbAck !== 1'b1 && n < 16)
		begin
			@(posedge clock);
			n++;
		end
		if (n == 16)
		begin
			failures++;
			print_verdict();
		end
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		wbXfer(1'b1, idx, d, 4'h1, r);
	endtask

	task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		wbXfer(1'b0, idx, 8'h00, 4'hf, r);
		check(r, exp);
	endtask

	task automatic doReset;
		rst_n <= 1'b0;
		tick(2);
		check(secondStageOff, 1'b0);
		tick(1);
		rst_n <= 1'b1;
		tick(1);
	endtask

	task automatic waitClear;
		int n;
		n = 0;
		while (secondStageOff !== 1'b0 && n < 10400)
		begin
			tick(1);
			n++;
		end
	endtask

	// One switching cycle of 600 clocks; overcurrent window 40..170, open-loop window 300..500
	task automatic swCycle(input logic oc, input logic ol);
		cycStart <= 1'b1;
		tick(4);
		cycStart <= 1'b0;
		tick(36);
		ocPin <= oc;
		tick(130);
		ocPin <= 1'b0;
		tick(130);
		olPin <= ol;
		tick(200);
		olPin <= 1'b0;
		tick(100);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testRegs;
		logic [31:0] r;
		tick(10);
		check(secondStageOff, 1'b1);
		rdChk(8'h4f, 32'h0);
		rdChk(8'h51, 32'h0);
		rdChk(8'h10, 32'h0);
		wbXfer(1'b1, 8'h50, 8'ha5, 4'h0, r);
		rdChk(8'h50, 32'h0);
		wr(8'h50, 8'ha5);
		rdChk(8'h50, 32'ha5);
		wr(8'h50, 8'h00);
		$display("registers test done");
	endtask

	task automatic testLevels;
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h4f, 8'h00);
			lvlPin <= 6'h01 << i;
			tick(6);
			check({26'h0, lvlFault}, 32'h1 << i);
			wr(8'h4f, 8'h01 << i);
			tick(6);
			check({26'h0, lvlFault}, 32'h0);
			lvlPin <= 6'h00;
		end
		wr(8'h4f, 8'h00);
		$display("level protections test done");
	endtask

	task automatic testIrq;
		logic [31:0] r;
		wr(8'h62, 8'h04);
		wr(8'h63, 8'hff);
		tick(2);
		check(irq, 1'b0);
		lvlPin <= 6'h20;
		tick(6);
		check(irq, 1'b1);
		wbXfer(1'b0, 8'h61, 8'h00, 4'hf, r);
		check(r[2], 1'b1);
		wr(8'h62, 8'h00);
		tick(2);
		check(irq, 1'b0);
		lvlPin <= 6'h00;
		tick(6);
		wr(8'h62, 8'h04);
		tick(2);
		check(irq, 1'b1);
		wr(8'h63, 8'h04);
		tick(2);
		check(irq, 1'b0);
		$display("interrupt test done");
	endtask

	task automatic testOvercurrent;
		wr(8'h51, 8'h52);
		waitClear();
		check(secondStageOff, 1'b0);
		wr(8'h50, 8'hf0);
		repeat (3) swCycle(1'b1, 1'b0);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b0);
		wr(8'h50, 8'h00);
		wr(8'h4f, 8'h80);
		repeat (3) swCycle(1'b1, 1'b0);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b0);
		wr(8'h4f, 8'h00);
		swCycle(1'b0, 1'b0);
		swCycle(1'b1, 1'b0);
		swCycle(1'b0, 1'b0);
		swCycle(1'b1, 1'b0);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b0);
		swCycle(1'b1, 1'b0);
		swCycle(1'b1, 1'b0);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b1);
		tick(5300);
		check(secondStageOff, 1'b1);
		doReset();
		$display("overcurrent test done");
	endtask

	task automatic testOpenLoop;
		wr(8'h51, 8'h22);
		waitClear();
		check(secondStageOff, 1'b0);
		wr(8'h50, 8'h0e);
		swCycle(1'b0, 1'b1);
		swCycle(1'b0, 1'b1);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b0);
		wr(8'h50, 8'h00);
		wr(8'h4f, 8'h40);
		swCycle(1'b0, 1'b1);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b0);
		wr(8'h4f, 8'h00);
		// Restart count 1 keeps the fault up for at least one full restart tick
		wr(8'h60, 8'h04);
		swCycle(1'b0, 1'b0);
		swCycle(1'b0, 1'b1);
		swCycle(1'b0, 1'b0);
		check(secondStageOff, 1'b1);
		waitClear();
		check(secondStageOff, 1'b0);
		$display("open loop test done");
	endtask

	task automatic testTemp;
		int n;
		wr(8'h50, 8'h00);
		n = 0;
		while (tempStrobe !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (tempStrobe !== 1'b1 && n < 3000);
		check(n, 2560);
		wr(8'h50, 8'h01);
		n = 0;
		while (tempStrobe !== 1'b1 && n < 41000)
		begin
			tick(1);
			n++;
		end
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (tempStrobe !== 1'b1 && n < 3000);
		check(n, 3000);
		$display("temperature sampling test done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		@(posedge clock);
		doReset();
		testRegs();
		testLevels();
		testIrq();
		testOvercurrent();
		testOpenLoop();
		testTemp();
		print_verdict();
	end

	initial
	begin
		repeat (120000) @(posedge clock);
		failures++;
		print_verdict();
	end
endmodule
